//--- bciu_core.sv
/*
 * Block control and interrupt unit: clears, conditional hold, interrupt
 * mask, fault setting and interrupt enable control.
 * Assumes the instruction sequencer, channels and typewriter logic run
 * on clk_sys; the neighbour processor request is a pin and is synced.
 */
// How it works
// - Clear-block clears each masked channel and the search/move control.
// - Bits 9 and 10 equal: full channel clear plus 5.5 us clear pulse.
// - Bit 9 low, bit 10 high: channel logic only, no clear pulse.
// - Bit 8 resets typewriter and its load/dump transfer logic.
// - Hold keeps program address while any masked condition is active.
// - Hold longer than 40 ms ends with reject word at P+1.
// - No active masked condition, or all drop: skip to P+2.
// - Enabled interrupt ends hold; hold address saved as interrupted.
// - Typewriter bits 8-10 never hold; reject if present, else skip.
// - Clear-pending clears selected conditions; channels internal only.
// - Mask bits: channels 0-7, clock, exp/BCD, arith, search/move.
// - Set-mask sets mask bits where operand bit is one.
// - Mask bits of absent channels can never be set.
// - Clear-mask clears mask bits where operand bit is one.
// - Neighbour interrupt request stays active until reset; nothing else clears it.
// - Set-float-fault sets the floating-point fault logic.
// - Set-decimal-fault sets the BCD fault logic.
// - Disable stops interrupts until enable; conditions stay sensable.
// - After enable, one more instruction runs before an interrupt.
`timescale 1ns/10ps
module bciu_core
  import bciu_pkg::*;
#(
  parameter logic [7:0]  CHAN_PRESENT = 8'hff,      // fitted channels
  parameter int unsigned HOLD_CYC     = HOLD_LIMIT_CYC // pause timeout
) (
  input  wire logic           clk_sys,        // 40 MHz clock
  input  wire logic           rst_b,          // Sync reset, active low
  input  wire bciu_instr_t    instr,          // Issued instruction
  input  wire logic           instr_done,     // Sequencer finished one
  input  wire logic [7:0]     chan_busy,      // R/W or connect set
  input  wire logic [7:0]     chan_int_irq,   // Channel-made interrupt
  input  wire logic [7:0]     chan_ext_irq,   // Equipment interrupt lvl
  input  wire logic           rtc_irq,        // Real-time clock event
  input  wire logic           exp_fault,      // Exponent fault event
  input  wire logic           arith_fault,    // Overflow/divide event
  input  wire logic           srch_done,      // Search/move complete
  input  wire logic           srch_busy,      // Search/move running
  input  wire logic           type_busy,      // Typewriter busy
  input  wire logic           type_nfinish,   // Finish not set
  input  wire logic           type_nrepeat,   // Repeat not set
  input  wire logic           nbr_req_pin,    // From right neighbour
  input  wire logic           irq_ack,        // Interrupt taken
  output logic [7:0]          chan_clear,     // Channel logic clear
  output logic [7:0]          equip_clear,    // 5.5 us clear pulse
  output logic                srch_clear,     // Search/move clear
  output logic                type_clear,     // Typewriter clear
  output logic                hold_p,         // Freeze program address
  output bciu_hold_res_t      hold_res,       // Hold outcome pulse
  output logic                nbr_irq_out,    // To left neighbour
  output logic                float_fault,    // Float fault latched
  output logic                dec_fault,      // BCD fault latched
  output logic                irq_req,        // Interrupt request
  output logic [11:0]         pend_vec,       // Sensable conditions
  output logic [11:0]         interrupt_enable_mask, // Mask readback
  output logic                ie_state        // Interrupt control on
);

  // Elaboration check: the timeout counter needs at least two cycles
  if (HOLD_CYC < 2) begin : g_bad_hold
    $error("HOLD_CYC too small");
  end

  // Decode of the issued instruction
  wire logic is_clr_blk = instr.valid && instr.code == OP_CLEAR_BLOCK;
  wire logic is_clr_pnd = instr.valid && instr.code == OP_CLEAR_PENDING;
  wire logic is_set_msk = instr.valid && instr.code == OP_SET_MASK;
  wire logic is_clr_msk = instr.valid && instr.code == OP_CLR_MASK;
  wire logic is_nbr     = instr.valid && instr.code == OP_NEIGHBOUR;
  wire logic is_hold    = instr.valid && instr.code == OP_HOLD;
  wire logic is_flt     = instr.valid && instr.code == OP_FLOAT_FAULT;
  wire logic is_dec     = instr.valid && instr.code == OP_DEC_FAULT;
  wire logic is_dis     = instr.valid && instr.code == OP_DISABLE;
  wire logic is_ena     = instr.valid && instr.code == OP_ENABLE;
  wire logic [11:0] opnd = instr.operand;

  // Clearing decode
  wire logic [7:0] sel_chan = opnd[CHAN_HI:CHAN_LO] & CHAN_PRESENT;
  wire logic xmit_clr = opnd[BIT_NOXMIT0] == opnd[BIT_NOXMIT1];
  wire logic [7:0] nxt_chan_clear = is_clr_blk ? sel_chan : 8'h00;
  wire logic [7:0] pulse_sel =
    (is_clr_blk && xmit_clr) ? sel_chan : 8'h00;

  logic [7:0]  chan_clear_ff;
  logic        srch_clear_ff;
  logic        type_clear_ff;
  logic [7:0]  equip_sel_ff;
  logic [15:0] pulse_cnt_ff;

  // Clear strobes, one cycle each
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      chan_clear_ff <= 8'h00;
      srch_clear_ff <= 1'b0;
      type_clear_ff <= 1'b0;
    end else begin
      chan_clear_ff <= nxt_chan_clear;
      srch_clear_ff <= is_clr_blk && opnd[BIT_SRCH];
      type_clear_ff <= is_clr_blk && opnd[BIT_TYPE];
    end
  end

  // Equipment clear pulse timer; a new clear restarts it
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      equip_sel_ff <= 8'h00;
      pulse_cnt_ff <= 16'h0000;
    end else if (pulse_sel != 8'h00) begin
      equip_sel_ff <= pulse_sel;
      pulse_cnt_ff <= 16'(CLR_PULSE_CYC);
    end else if (pulse_cnt_ff > 16'h0001) begin
      pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
    end else begin
      pulse_cnt_ff <= 16'h0000;
      equip_sel_ff <= 8'h00;
    end
  end

  assign chan_clear  = chan_clear_ff;
  assign srch_clear  = srch_clear_ff;
  assign type_clear  = type_clear_ff;
  assign equip_clear = equip_sel_ff;

  // Neighbour request synchroniser
  logic nbr_s1_ff;
  logic nbr_s2_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      nbr_s1_ff <= 1'b0;
      nbr_s2_ff <= 1'b0;
    end else begin
      nbr_s1_ff <= nbr_req_pin;
      nbr_s2_ff <= nbr_s1_ff;
    end
  end

  // Interrupt mask register
  logic [11:0] mask_ff;
  wire logic [11:0] settable = {4'hf, CHAN_PRESENT};
  wire logic [11:0] nxt_mask =
    is_set_msk ? (mask_ff | (opnd & settable)) :
    is_clr_msk ? (mask_ff & ~opnd) : mask_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) mask_ff <= MASK_RESET;
    else        mask_ff <= nxt_mask;
  end
  assign interrupt_enable_mask = mask_ff;

  // Sticky pending conditions; set wins over clear
  logic [11:0] pend_ff;
  logic        flt_ff;
  logic        dec_ff;
  wire logic [11:0] set_ev = {srch_done, arith_fault,
                              exp_fault | is_flt | is_dec,
                              rtc_irq, chan_int_irq};
  // Clear-block also drops the channel interrupts it clears
  wire logic [11:0] clr_sel = is_clr_pnd ? opnd :
                              is_clr_blk ? {4'h0, sel_chan} : 12'h000;
  wire logic [11:0] nxt_pend = set_ev | (pend_ff & ~clr_sel);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pend_ff <= 12'h000;
      flt_ff  <= 1'b0;
      dec_ff  <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      flt_ff  <= is_flt | (flt_ff & ~clr_sel[IRQ_EXPBCD]);
      dec_ff  <= is_dec | (dec_ff & ~clr_sel[IRQ_EXPBCD]);
    end
  end
  assign float_fault = flt_ff;
  assign dec_fault   = dec_ff;
  // External equipment lines are levels, not cleared here
  assign pend_vec = pend_ff | {4'h0, chan_ext_irq};

  // Outgoing neighbour request held until reset; no acknowledge clears it
  logic nbr_out_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_b)      nbr_out_ff <= 1'b0;
    else if (is_nbr) nbr_out_ff <= 1'b1;
  end
  assign nbr_irq_out = nbr_out_ff;

  // Interrupt enable with one-instruction delay after enable
  logic ie_ff;
  logic ie_wait_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ie_ff      <= ENA_RESET;
      ie_wait_ff <= 1'b0;
    end else if (is_dis) begin
      ie_ff      <= 1'b0;
      ie_wait_ff <= 1'b0;
    end else if (is_ena) begin
      ie_ff      <= 1'b1;
      ie_wait_ff <= 1'b1;
    end else if (ie_wait_ff && instr.valid) begin
      ie_wait_ff <= 1'b0;
    end
  end
  assign ie_state = ie_ff;
  wire logic irq_any = |(pend_vec & mask_ff) | nbr_s2_ff;
  assign irq_req = ie_ff && !ie_wait_ff && irq_any;

  // Conditional hold sequencer
  typedef enum logic [0:0] {H_IDLE, H_WAIT} bciu_hstate_t;
  bciu_hstate_t hst_ff;
  logic [11:0]  hmask_ff;
  logic [31:0]  hcnt_ff;
  bciu_hold_res_t res_ff;
  wire logic [11:0] cond = {srch_busy, type_nrepeat, type_nfinish,
                            type_busy, chan_busy};
  wire logic typ_sel = |opnd[10:8];
  wire logic typ_hit = |(opnd[10:8] & cond[10:8]);
  wire logic now_hit = |(opnd & cond);
  wire logic w_hit   = |(hmask_ff & cond);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hst_ff   <= H_IDLE;
      hmask_ff <= 12'h000;
      hcnt_ff  <= 32'h0000_0000;
      res_ff   <= HOLD_NONE;
    end else begin
      res_ff <= HOLD_NONE;
      unique case (hst_ff)
        H_IDLE: if (is_hold) begin
          hmask_ff <= opnd;
          hcnt_ff  <= 32'h0000_0000;
          if (typ_sel) res_ff <= typ_hit ? HOLD_REJECT : HOLD_SKIP;
          else if (!now_hit) res_ff <= HOLD_SKIP;
          else hst_ff <= H_WAIT;
        end
        H_WAIT: begin
          hcnt_ff <= hcnt_ff + 32'h0000_0001;
          if (irq_req) begin
            res_ff <= HOLD_IRQ;
            hst_ff <= H_IDLE;
          end else if (!w_hit) begin
            res_ff <= HOLD_SKIP;
            hst_ff <= H_IDLE;
          end else if (hcnt_ff >= 32'(HOLD_CYC - 1)) begin
            res_ff <= HOLD_REJECT;
            hst_ff <= H_IDLE;
          end
        end
      endcase
    end
  end
  assign hold_p   = hst_ff == H_WAIT;
  assign hold_res = res_ff;

  // Checks
  a_mask_set_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_set_msk |=> (interrupt_enable_mask & ($past(opnd) & settable))
                   == ($past(opnd) & settable))
    else $error("mask set failed");
  a_mask_clr_bits: assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_clr_msk |=> (interrupt_enable_mask & $past(opnd)) == 12'h000)
    else $error("mask clear failed");
  a_absent_chan: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (interrupt_enable_mask[7:0] & ~CHAN_PRESENT) == 8'h00)
    else $error("absent channel mask set");
  a_clear_chan: assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_clr_blk |=> chan_clear == ($past(sel_chan)))
    else $error("channel clear wrong");
  // Length of the standing equipment clear, for the pulse check
  logic [15:0] plen_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_b)                    plen_ff <= 16'h0000;
    else if (pulse_sel != 8'h00)   plen_ff <= 16'h0001;
    else if (equip_clear != 8'h00) plen_ff <= plen_ff + 16'h0001;
    else                           plen_ff <= 16'h0000;
  end
  a_pulse_len: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(equip_clear != 8'h00) |->
      $past(plen_ff) == 16'(CLR_PULSE_CYC))
    else $error("clear pulse length wrong");
  a_no_xmit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (is_clr_blk && !opnd[9] && opnd[10] && equip_clear == 8'h00)
    |=> equip_clear == 8'h00)
    else $error("pulse sent when barred");
  a_type_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (is_clr_blk && opnd[BIT_TYPE]) |=> type_clear)
    else $error("typewriter not cleared");
  a_enable_delay: assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_ena |=> !irq_req)
    else $error("irq right after enable");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    irq_req |-> ie_state && irq_any)
    else $error("irq while disabled");
  a_disable_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_dis |=> !ie_state && !irq_req)
    else $error("disable ignored");
  a_hold_typ: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hst_ff == H_IDLE && is_hold && typ_sel) |=> !hold_p)
    else $error("typewriter hold");
  a_hold_skip: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hold_p && !w_hit && !irq_req) |=> hold_res == HOLD_SKIP)
    else $error("no skip on release");
  a_hold_irq: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (hold_p && irq_req) |=> hold_res == HOLD_IRQ)
    else $error("irq did not end hold");
  a_hold_time: assert property (@(posedge clk_sys) disable iff (!rst_b)
    hold_p |-> hcnt_ff < 32'(HOLD_CYC))
    else $error("hold overran");
  a_nbr_stays: assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_nbr |=> nbr_irq_out[*4])
    else $error("neighbour irq dropped");
  a_flt_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_flt |=> float_fault)
    else $error("float fault not set");
  a_dec_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_dec |=> dec_fault)
    else $error("bcd fault not set");
  a_pend_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (is_clr_pnd && set_ev == 12'h000) |=> (pend_ff & $past(opnd)) == 12'h0)
    else $error("pending not cleared");
  a_mask_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(is_set_msk || is_clr_msk) |=> $stable(interrupt_enable_mask))
    else $error("mask changed unasked");
  a_rtc_pend: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rtc_irq |=> pend_vec[IRQ_RTC])
    else $error("clock event lost");

  c_hold_timeout: cover property (@(posedge clk_sys) hold_res == HOLD_REJECT);
  c_hold_irq: cover property (@(posedge clk_sys) hold_res == HOLD_IRQ);
  c_pulse: cover property (@(posedge clk_sys) equip_clear != 8'h00);
  c_irq: cover property (@(posedge clk_sys) irq_req);

endmodule : bciu_core

//--- bciu_pkg.sv
/*
 * Package for the block control and interrupt unit: instruction codes,
 * mask bit positions, timing constants and the carrier structs.
 * Assumes a single 40 MHz system clock.
 */
package bciu_pkg;

  // Clock rate and timing
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned CLR_PULSE_NS   = 5500;  // 5.5 us clear pulse
  localparam int unsigned CLR_PULSE_CYC  =
    (CLR_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HOLD_LIMIT_MS  = 40;    // pause timeout
  localparam int unsigned HOLD_LIMIT_CYC = HOLD_LIMIT_MS * (CLK_HZ / 1000);

  // Instruction function codes (sub-code after 77)
  localparam logic [5:0] OP_CLEAR_PENDING = 6'h28; // 77.50
  localparam logic [5:0] OP_CLEAR_BLOCK   = 6'h29; // 77.51
  localparam logic [5:0] OP_SET_MASK      = 6'h2a; // 77.52
  localparam logic [5:0] OP_CLR_MASK      = 6'h2b; // 77.53
  localparam logic [5:0] OP_NEIGHBOUR     = 6'h2f; // 77.57
  localparam logic [5:0] OP_HOLD          = 6'h30; // 77.6x
  localparam logic [5:0] OP_FLOAT_FAULT   = 6'h39; // 77.71
  localparam logic [5:0] OP_DEC_FAULT     = 6'h3a; // 77.72
  localparam logic [5:0] OP_DISABLE       = 6'h3b; // 77.73
  localparam logic [5:0] OP_ENABLE        = 6'h3c; // 77.74

  // Field positions of the 12-bit operand mask
  localparam int unsigned CHAN_LO     = 0;
  localparam int unsigned CHAN_HI     = 7;
  localparam int unsigned BIT_TYPE    = 8;
  localparam int unsigned BIT_NOXMIT0 = 9;
  localparam int unsigned BIT_NOXMIT1 = 10;
  localparam int unsigned BIT_SRCH    = 11;
  localparam int unsigned IRQ_RTC     = 8;
  localparam int unsigned IRQ_EXPBCD  = 9;
  localparam int unsigned IRQ_ARITH   = 10;
  localparam int unsigned IRQ_SRCH    = 11;

  // Reset values
  localparam logic [11:0] MASK_RESET = 12'h000;
  localparam logic        ENA_RESET  = 1'b0;

  // Instruction from the sequencer
  typedef struct packed {
    logic        valid;   // one-cycle issue strobe
    logic [5:0]  code;    // function code
    logic [11:0] operand; // 12-bit mask field
  } bciu_instr_t;

  // Hold outcome to the sequencer
  typedef enum logic [1:0] {
    HOLD_NONE,
    HOLD_REJECT,   // read reject word at P+1
    HOLD_SKIP,     // skip to P+2
    HOLD_IRQ       // interrupt, save P of the hold
  } bciu_hold_res_t;

endpackage : bciu_pkg

//--- bciu_far_model.sv
/*
 * Far-side model: eight I/O channels plus the search/move unit (slot 8).
 * Assumes the bench pulses start bits and the core sends its clears,
 * all on clk_sys; outputs change only by non-blocking update on the edge.
 */
`timescale 1ns/10ps
module bciu_far_model #(
  parameter int LEN = 10  // Cycles a unit stays busy
) (
  input  wire logic       clk_sys,  // 40 MHz clock
  input  wire logic       rst_b,    // Sync reset, active low
  input  wire logic [8:0] start,    // Start a unit
  input  wire logic [8:0] stuck,    // Unit never finishes
  input  wire logic [8:0] clr,      // Clear from the core
  output logic      [8:0] busy_ff,  // Unit busy level
  output logic      [8:0] done_ff   // Completion pulse
);
  int cnt_ff [9];

  // Each unit counts down and pulses done; a clear drops it silently
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 9; i++) begin
      done_ff[i] <= 1'b0;
      if (!rst_b || clr[i]) begin
        busy_ff[i] <= 1'b0;
      end else if (start[i]) begin
        busy_ff[i] <= 1'b1;
        cnt_ff[i]  <= LEN;
      end else if (busy_ff[i] && !stuck[i]) begin
        cnt_ff[i] <= cnt_ff[i] - 1;
        if (cnt_ff[i] == 1) begin
          busy_ff[i] <= 1'b0;
          done_ff[i] <= 1'b1;
        end
      end
    end
  end
endmodule : bciu_far_model

//--- bciu_core_tb.sv
/*
 * Self-checking bench for bciu_core: issues instructions, drives the
 * condition lines and checks the core's outputs cycle by cycle.
 * Assumes bciu_pkg and bciu_far_model are compiled first.
 */
`timescale 1ns/10ps
module bciu_core_tb
  import bciu_pkg::*;
;
  localparam int HC = 50;  // Shortened hold timeout
  logic           clk_sys = 1'b0;
  logic           rst_b = 1'b0;
  bciu_instr_t    instr = '0;
  logic [8:0]     st = '0, stk = '0, busy, done;
  logic [7:0]     chan_ext_irq = '0, chan_clear, equip_clear;
  logic [2:0]     evs = '0, tl = '0;
  logic           srch_clear, type_clear, hold_p, nbr_irq_out;
  logic           float_fault, dec_fault, irq_req, ie_state;
  logic           nbr_pin = 1'b0;
  logic [11:0]    pend_vec, interrupt_enable_mask;
  bciu_hold_res_t hold_res;
  int             mismatches = 0, checked = 0, n;

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  bciu_far_model #(.LEN(10)) far (
    .clk_sys(clk_sys), .rst_b(rst_b), .start(st), .stuck(stk),
    .clr({srch_clear, chan_clear}), .busy_ff(busy), .done_ff(done));

  bciu_core #(.CHAN_PRESENT(8'h7f), .HOLD_CYC(HC)) DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .instr(instr), .instr_done(1'b0),
    .chan_busy(busy[7:0]), .chan_int_irq(done[7:0]),
    .chan_ext_irq(chan_ext_irq), .rtc_irq(evs[0]), .exp_fault(evs[1]),
    .arith_fault(evs[2]), .srch_done(done[8]), .srch_busy(busy[8]),
    .type_busy(tl[0]), .type_nfinish(tl[1]), .type_nrepeat(tl[2]),
    .nbr_req_pin(nbr_pin), .irq_ack(1'b0), .chan_clear(chan_clear),
    .equip_clear(equip_clear), .srch_clear(srch_clear),
    .type_clear(type_clear), .hold_p(hold_p), .hold_res(hold_res),
    .nbr_irq_out(nbr_irq_out), .float_fault(float_fault),
    .dec_fault(dec_fault), .irq_req(irq_req), .pend_vec(pend_vec),
    .interrupt_enable_mask(interrupt_enable_mask), .ie_state(ie_state));

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : chk

  // Issue one instruction; results of the taking edge are then visible
  task automatic issue(input logic [5:0] code, input logic [11:0] op);
    @(posedge clk_sys);
    #1;
    instr = '{valid: 1'b1, code: code, operand: op};
    tick;
    instr.valid = 1'b0;
  endtask : issue

  // One-cycle event pulse: 0 clock, 1 exponent, 2 arithmetic
  task automatic ev(input int b);
    evs[b] = 1'b1;
    tick;
    evs = '0;
  endtask : ev

  // Wait for the hold outcome, counting the cycles spent waiting
  task automatic wait_res(input bciu_hold_res_t exp, input int lo, hi);
    n = 0;
    while (hold_res === HOLD_NONE && n < 200) begin
      tick;
      n++;
    end
    chk(hold_res, exp, "hold result");
    chk(n >= lo && n <= hi, 1, "hold time");
  endtask : wait_res

  // Measure how long the equipment clear stands
  task automatic cnt_equip(input logic [7:0] sel);
    n = 0;
    while (equip_clear === sel && n < 400) begin
      tick;
      n++;
    end
    chk(n, CLR_PULSE_CYC, "pulse length");
    chk(equip_clear, 8'h00, "pulse end");
  endtask : cnt_equip

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // Cut a hang short; the tests need about 630 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    stop_test;
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    chk(interrupt_enable_mask, MASK_RESET, "mask reset");
    chk({ie_state, hold_p, nbr_irq_out, equip_clear}, '0, "reset");
    issue(OP_SET_MASK, 12'hfff);
    chk(interrupt_enable_mask, 12'hf7f, "set mask");
    issue(OP_CLR_MASK, 12'h0f0);
    chk(interrupt_enable_mask, 12'hf0f, "clear mask");
    issue(OP_CLR_MASK, 12'hfff);
    $display("mask test done");
    // Channels 1, 2 and search busy, then cleared with the pulse
    st = 9'h106;
    stk = 9'h106;
    tick;
    st = '0;
    issue(OP_CLEAR_BLOCK, 12'h806);
    chk({srch_clear, type_clear, chan_clear}, 10'h206, "sel");
    cnt_equip(8'h06);
    chk(busy, 9'h000, "units cleared");
    issue(OP_CLEAR_BLOCK, 12'h408);
    chk({equip_clear, chan_clear}, 16'h0008, "no pulse");
    issue(OP_CLEAR_BLOCK, 12'h710);
    chk({type_clear, chan_clear}, 9'h110, "type clear");
    cnt_equip(8'h10);
    $display("clear test done");
    // Hold on channel 0 until it finishes
    stk = '0;
    st = 9'h001;
    tick;
    st = '0;
    issue(OP_HOLD, 12'h001);
    chk(hold_p, 1'b1, "holding");
    wait_res(HOLD_SKIP, 6, 12);
    chk(pend_vec[0], 1'b1, "chan event");
    issue(OP_CLEAR_PENDING, 12'h001);
    chk(pend_vec[0], 1'b0, "chan cleared");
    issue(OP_HOLD, 12'h002);
    chk(hold_p, 1'b0, "no hold");
    wait_res(HOLD_SKIP, 0, 0);
    st = 9'h008;
    stk = 9'h008;
    tick;
    st = '0;
    issue(OP_HOLD, 12'h008);
    wait_res(HOLD_REJECT, HC - 2, HC + 2);
    issue(OP_CLEAR_BLOCK, 12'h408);
    // Typewriter conditions never hold
    for (int i = 0; i < 3; i++) begin
      tl = 3'b001 << i;
      issue(OP_HOLD, 12'h100 << i);
      chk(hold_p, 1'b0, "type no hold");
      wait_res(HOLD_REJECT, 0, 0);
      tl = '0;
      issue(OP_HOLD, 12'h100 << i);
      wait_res(HOLD_SKIP, 0, 0);
    end
    $display("hold test done");
    ev(0);
    chk({irq_req, pend_vec[8]}, 2'b01, "sensed disabled");
    issue(OP_SET_MASK, 12'h100);
    chk(irq_req, 1'b0, "disabled");
    issue(OP_ENABLE, 12'h000);
    chk({ie_state, irq_req}, 2'b10, "enable delay");
    issue(OP_CLR_MASK, 12'h000);
    chk(irq_req, 1'b1, "taken");
    issue(OP_CLR_MASK, 12'h100);
    chk(irq_req, 1'b0, "masked");
    issue(OP_SET_MASK, 12'h100);
    issue(OP_CLEAR_PENDING, 12'h100);
    chk({irq_req, pend_vec[8]}, 2'b00, "pend cleared");
    // Interrupt ends a hold on channel 4
    st = 9'h010;
    stk = 9'h010;
    tick;
    st = '0;
    issue(OP_HOLD, 12'h010);
    repeat (3) tick;
    ev(0);
    wait_res(HOLD_IRQ, 0, 2);
    issue(OP_CLEAR_PENDING, 12'h100);
    issue(OP_CLEAR_BLOCK, 12'h410);
    issue(OP_DISABLE, 12'h000);
    ev(0);
    chk({ie_state, irq_req, pend_vec[8]}, 3'b001, "off");
    issue(OP_CLEAR_PENDING, 12'h100);
    $display("interrupt test done");
    // Other sources; external channel lines are not cleared
    stk = '0;
    ev(1);
    ev(2);
    st = 9'h100;
    tick;
    st = '0;
    repeat (12) tick;
    chan_ext_irq = 8'h20;
    issue(OP_CLEAR_PENDING, 12'h020);
    chk(pend_vec, 12'he20, "sources");
    chan_ext_irq = '0;
    issue(OP_CLEAR_PENDING, 12'he00);
    chk(pend_vec, 12'h000, "all clear");
    issue(OP_FLOAT_FAULT, 12'h000);
    chk({float_fault, pend_vec[9]}, 2'b11, "float fault");
    issue(OP_DEC_FAULT, 12'h000);
    chk({float_fault, dec_fault}, 2'b11, "dec fault");
    issue(OP_CLEAR_PENDING, 12'h200);
    chk({float_fault, dec_fault, pend_vec}, 14'h0000, "faults clear");
    issue(OP_NEIGHBOUR, 12'h000);
    repeat (20) tick;
    chk(nbr_irq_out, 1'b1, "neighbour");
    // Incoming neighbour request interrupts once enabled
    issue(OP_ENABLE, 12'h000);
    issue(OP_CLR_MASK, 12'h000);
    chk(irq_req, 1'b0, "no source");
    nbr_pin = 1'b1;
    repeat (3) tick;
    chk(irq_req, 1'b1, "neighbour in");
    nbr_pin = 1'b0;
    // Mid-run reset drops the held request, mask and enable
    rst_b = 1'b0;
    repeat (2) tick;
    rst_b = 1'b1;
    chk({nbr_irq_out, ie_state, interrupt_enable_mask}, '0, "rerun");
    $display("source test done");
    stop_test;
  end
endmodule : bciu_core_tb
